//--- core/host_bridge_config_header_regs.sv
// Host bridge device 0 configuration header registers and egress window decode
// Overview of operation
// - Latency slot reads zero, ignores writes
// - Header type always reads zero
// - Header type access has no side effects
// - Subsystem vendor field takes first write only
// - Subsystem field takes first write only
// - Capability pointer reads fixed E0h
// - Window disabled after reset, bit0 enables
// - Claim window accesses only when enabled
// - Base field holds address bits 35:12
// - Decode 4 KB window on bits above 11
// - Claimed accesses routed to egress registers
// - Lock mode freezes all writable window bits
`timescale 1ns/1ps
module host_bridge_config_header_regs #(
  parameter int MEM_ADDR_W = host_bridge_cfg_pkg::MEM_ADDR_W
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic [7:0]            cfg_addr_i,
  input  wire logic [3:0]            cfg_be_i,
  input  wire logic [31:0]           cfg_wdata_i,
  output logic      [31:0]           cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  input  wire logic                  lock_mode_i,
  input  wire logic                  mem_req_i,
  input  wire logic [MEM_ADDR_W-1:0] mem_addr_i,
  output logic                       mem_claim_o,
  output logic      [11:0]           mem_offset_o,
  output logic                       win_enable_o
);
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        claim_reg;
  logic        claim_next;
  logic [11:0] offset_reg;
  logic        en_reg;
  logic        en_next;
  logic [23:0] base_reg;
  logic [23:0] base_next;
  logic [27:0] upper_reg;
  logic [27:0] upper_next;
  logic [15:0] subsystem_vendor_ident_value;
  logic [15:0] sid_value;

  wire         hit_lat_hdr;
  wire         hit_subsys;
  wire         hit_cap_ptr;
  wire         hit_win_lo;
  wire         hit_win_hi;
  wire         win_wr_ok;
  wire         win_lo_wr;
  wire         win_hi_wr;
  wire         win_base_hit;
  wire  [23:0] addr_page;
  wire  [11:0] win_offset;
  wire  [31:0] lat_hdr_word;
  wire  [31:0] cap_ptr_word;
  wire  [31:0] subsys_word;
  wire         subsystem_vendor_ident_wr;
  wire         sid_wr;
  wire  [31:0] win_lo_word;
  wire  [31:0] win_hi_word;
  wire  [31:0] win_lo_merged;
  wire  [31:0] win_hi_merged;

  // Byte-lane merge of write data over a current dword
  function automatic logic [31:0] merge_be(input logic [31:0] cur,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Dword select decode of a configuration byte address
  function automatic logic dw_hit(input logic [7:0] addr,
                                  input logic [5:0] dw);
    return addr[7:2] == dw;
  endfunction

  assign hit_lat_hdr = dw_hit(cfg_addr_i, host_bridge_cfg_pkg::DW_LAT_HDR);
  assign hit_subsys  = dw_hit(cfg_addr_i, host_bridge_cfg_pkg::DW_SUBSYS);
  assign hit_cap_ptr = dw_hit(cfg_addr_i, host_bridge_cfg_pkg::DW_CAP_PTR);
  assign hit_win_lo  = dw_hit(cfg_addr_i, host_bridge_cfg_pkg::DW_WIN_LO);
  assign hit_win_hi  = dw_hit(cfg_addr_i, host_bridge_cfg_pkg::DW_WIN_HI);
  assign win_wr_ok   = cfg_wr_i && !lock_mode_i;
  assign win_lo_wr   = win_wr_ok && hit_win_lo;
  assign win_hi_wr   = win_wr_ok && hit_win_hi;

  // Subsystem identifiers: lanes 1:0 vendor, lanes 3:2 subsystem
  assign subsystem_vendor_ident_wr = cfg_wr_i && hit_subsys;
  assign sid_wr  = cfg_wr_i && hit_subsys;

  write_once_field u_subsystem_vendor_ident (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (subsystem_vendor_ident_wr),
    .be_i       (cfg_be_i[1:0]),
    .wdata_i    (cfg_wdata_i[15:0]),
    .value_o    (subsystem_vendor_ident_value),
    .locked_o   ()
  );

  write_once_field u_sid (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (sid_wr),
    .be_i       (cfg_be_i[3:2]),
    .wdata_i    (cfg_wdata_i[31:16]),
    .value_o    (sid_value),
    .locked_o   ()
  );

  // Window base register views; bits 11:1 always zero
  assign win_lo_word   = {base_reg[19:0], 11'h000, en_reg};
  assign win_hi_word   = {upper_reg, base_reg[23:20]};
  assign win_lo_merged = merge_be(win_lo_word, cfg_wdata_i, cfg_be_i);
  assign win_hi_merged = merge_be(win_hi_word, cfg_wdata_i, cfg_be_i);

  // Next state of the window register; reserved low bits are dropped
  assign en_next    = win_lo_wr ? win_lo_merged[0] : en_reg;
  assign base_next  = win_lo_wr ? {base_reg[23:20], win_lo_merged[31:12]} :
                      win_hi_wr ? {win_hi_merged[3:0], base_reg[19:0]} :
                      base_reg;
  assign upper_next = win_hi_wr ? win_hi_merged[31:4] : upper_reg;

  // Constant and subsystem words; latency and header bytes have no storage
  assign lat_hdr_word = {8'h00, host_bridge_cfg_pkg::HEADER_TYPE_VAL,
                         host_bridge_cfg_pkg::LATENCY_VAL, 8'h00};
  assign cap_ptr_word = {24'h000000, host_bridge_cfg_pkg::CAP_PTR_VAL};
  assign subsys_word  = {sid_value, subsystem_vendor_ident_value};

  // Read mux
  assign rdata_next = hit_lat_hdr ? lat_hdr_word :
                      hit_subsys  ? subsys_word  :
                      hit_cap_ptr ? cap_ptr_word :
                      hit_win_lo  ? win_lo_word  :
                      hit_win_hi  ? win_hi_word  :
                      32'h00000000;

  // Memory decode compares bits 35:12 only
  assign addr_page    = mem_addr_i[host_bridge_cfg_pkg::WIN_BASE_MSB:
                                   host_bridge_cfg_pkg::WIN_BASE_LSB];
  assign win_base_hit = addr_page == base_reg;
  assign win_offset   = mem_addr_i[host_bridge_cfg_pkg::WIN_OFFSET_W-1:0];
  assign claim_next   = mem_req_i && en_reg && win_base_hit;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_reg    <= 1'b0;
      base_reg  <= host_bridge_cfg_pkg::WIN_BASE_RST;
      upper_reg <= host_bridge_cfg_pkg::WIN_UPPER_RST;
    end else begin
      en_reg    <= en_next;
      base_reg  <= base_next;
      upper_reg <= upper_next;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg  <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= cfg_rd_i;
      rdata_reg  <= cfg_rd_i ? rdata_next : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      claim_reg  <= 1'b0;
      offset_reg <= 12'h000;
    end else begin
      claim_reg  <= claim_next;
      offset_reg <= claim_next ? win_offset : 12'h000;
    end
  end

  assign cfg_rdata_o  = rdata_reg;
  assign cfg_rvalid_o = rvalid_reg;
  assign mem_claim_o  = claim_reg;
  assign mem_offset_o = offset_reg;
  assign win_enable_o = en_reg;
endmodule

//--- inc/host_bridge_cfg_pkg.sv
// Constants for the host bridge configuration header block
package host_bridge_cfg_pkg;
  localparam int          CFG_ADDR_W        = 8;
  localparam int          MEM_ADDR_W        = 36;
  // Dword indices (byte offset / 4) of the decoded configuration dwords
  localparam logic [5:0]  DW_LAT_HDR        = 6'h03;
  localparam logic [5:0]  DW_SUBSYS         = 6'h0b;
  localparam logic [5:0]  DW_CAP_PTR        = 6'h0d;
  localparam logic [5:0]  DW_WIN_LO         = 6'h10;
  localparam logic [5:0]  DW_WIN_HI         = 6'h11;
  // Byte offsets of the registers
  localparam logic [7:0]  OFF_LATENCY       = 8'h0d;
  localparam logic [7:0]  OFF_HEADER_TYPE   = 8'h0e;
  localparam logic [7:0]  OFF_SUBSYS_VENDOR = 8'h2c;
  localparam logic [7:0]  OFF_SUBSYS_IDENT  = 8'h2e;
  localparam logic [7:0]  OFF_CAP_PTR       = 8'h34;
  localparam logic [7:0]  OFF_WIN_BASE      = 8'h40;
  // Fixed read values and reset values
  localparam logic [7:0]  LATENCY_VAL       = 8'h00;
  localparam logic [7:0]  HEADER_TYPE_VAL   = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL       = 8'he0;
  localparam logic [15:0] SUBSYS_RST        = 16'h0000;
  localparam logic [23:0] WIN_BASE_RST      = 24'h000000;
  localparam logic [27:0] WIN_UPPER_RST     = 28'h0000000;
  // Field positions of the window base register
  localparam int          WIN_EN_BIT        = 0;
  localparam int          WIN_BASE_LSB      = 12;
  localparam int          WIN_BASE_MSB      = 35;
  localparam int          WIN_UPPER_LSB     = 36;
  localparam int          WIN_OFFSET_W      = 12;
endpackage

//--- core/write_once_field.sv
// Sixteen-bit field that keeps only the first write after reset
`timescale 1ns/1ps
module write_once_field (
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wr_i,
  input  wire logic [1:0]  be_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] value_o,
  output logic             locked_o
);
  logic [15:0] value_reg;
  logic [15:0] value_next;
  logic        locked_reg;
  wire         take_write;

  assign take_write = wr_i && (|be_i) && !locked_reg;
  assign value_next = {be_i[1] ? wdata_i[15:8] : value_reg[15:8],
                       be_i[0] ? wdata_i[7:0]  : value_reg[7:0]};

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_reg  <= host_bridge_cfg_pkg::SUBSYS_RST;
      locked_reg <= 1'b0;
    end else if (take_write) begin
      value_reg  <= value_next;
      locked_reg <= 1'b1;
    end
  end

  assign value_o  = value_reg;
  assign locked_o = locked_reg;
endmodule

//--- bench/host_bridge_config_header_regs_sva.sv
// Port assertions for the configuration header block
`timescale 1ns/1ps
module cfg_header_sva #(parameter int MEM_ADDR_W = 36) (
  input wire logic                  core_clk_i,
  input wire logic                  rstn_i,
  input wire logic                  cfg_rd_i,
  input wire logic                  cfg_wr_i,
  input wire logic [7:0]            cfg_addr_i,
  input wire logic [3:0]            cfg_be_i,
  input wire logic [31:0]           cfg_wdata_i,
  input wire logic [31:0]           cfg_rdata_o,
  input wire logic                  cfg_rvalid_o,
  input wire logic                  lock_mode_i,
  input wire logic                  mem_req_i,
  input wire logic [MEM_ADDR_W-1:0] mem_addr_i,
  input wire logic                  mem_claim_o,
  input wire logic [11:0]           mem_offset_o,
  input wire logic                  win_enable_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire [5:0]  dw     = cfg_addr_i[7:2];
  wire        wd0    = cfg_wdata_i[0];
  wire [11:0] lo_adr = mem_addr_i[11:0];
  a_read_answer: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  a_idle_quiet: assert property (!cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0)
    else $error("read answer without read");
  a_lat_hdr_zero: assert property (cfg_rd_i && dw == 6'h03 |=> cfg_rdata_o == 32'h0)
    else $error("latency or header type not zero");
  a_cap_ptr_fixed: assert property (cfg_rd_i && dw == 6'h0d |=> cfg_rdata_o == 32'he0)
    else $error("capability pointer wrong");
  a_win_rsvd_zero: assert property (cfg_rd_i && dw == 6'h10 |=> cfg_rdata_o[11:1] == 11'h0)
    else $error("window reserved bits not zero");
  a_lock_freeze: assert property (lock_mode_i |=> win_enable_o == $past(win_enable_o))
    else $error("enable changed under lock");
  a_enable_write: assert property (cfg_wr_i && dw == 6'h10 && cfg_be_i[0] && !lock_mode_i
    |=> win_enable_o == $past(wd0))
    else $error("enable bit not written");
  a_no_claim_off: assert property (!mem_req_i || !win_enable_o |=> !mem_claim_o)
    else $error("claim without enabled request");
  a_claim_offset: assert property (mem_claim_o |-> mem_offset_o == $past(lo_adr))
    else $error("claimed offset wrong");
  a_offset_idle: assert property (!mem_claim_o |-> mem_offset_o == 12'h0)
    else $error("offset without claim");
endmodule
bind host_bridge_config_header_regs cfg_header_sva #(.MEM_ADDR_W(MEM_ADDR_W)) i_sva (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
  .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .lock_mode_i(lock_mode_i),
  .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i), .mem_claim_o(mem_claim_o),
  .mem_offset_o(mem_offset_o), .win_enable_o(win_enable_o));

//--- bench/cfg_host_model.sv
// Host model issuing configuration reads and writes
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_rvalid_i,
  output logic             cfg_rd_o,
  output logic             cfg_wr_o,
  output logic      [7:0]  cfg_addr_o,
  output logic      [3:0]  cfg_be_o,
  output logic      [31:0] cfg_wdata_o
);
  initial begin
    {cfg_rd_o, cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge core_clk_i);
    {cfg_wr_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} <= {1'b1, a, b, d};
    @(posedge core_clk_i);
    cfg_wr_o    <= 1'b0;
    cfg_wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    d = 32'hx;
    @(posedge core_clk_i);
    cfg_rd_o   <= 1'b1;
    cfg_addr_o <= a;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk_i);
      cfg_rd_o <= 1'b0;
      #1;
      if (cfg_rvalid_i === 1'b1) begin
        d = cfg_rdata_i;
        break;
      end
    end
  endtask
endmodule

//--- bench/tb_host_bridge_config_header_regs.sv
// Self-checking bench for the configuration header block
`timescale 1ns/1ps
module tb_host_bridge_config_header_regs;
  logic        core_clk_i  = 1'b0;
  logic        rstn_i      = 1'b0;
  logic        lock_mode_i = 1'b0;
  logic        mem_req_i   = 1'b0;
  logic [35:0] mem_addr_i  = 36'h0;
  logic        rd, wr, rvalid, claim, en;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, d;
  logic [11:0] off;
  int          error_cnt   = 0;
  int          comparisons = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  cfg_host_model i_host (.core_clk_i(core_clk_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid),
    .cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wdata));
  host_bridge_config_header_regs i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .lock_mode_i(lock_mode_i),
    .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i), .mem_claim_o(claim),
    .mem_offset_o(off), .win_enable_o(en));
  task check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd(a, d);
    check(d, exp);
  endtask
  task mchk(input logic [35:0] a, input logic c, input logic [11:0] o);
    @(posedge core_clk_i);
    {mem_req_i, mem_addr_i} <= {1'b1, a};
    @(posedge core_clk_i);
    mem_req_i <= 1'b0;
    #1;
    check(claim, c);
    check(off, o);
  endtask
  task give_verdict;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rchk(8'h0c, 32'h0);
    check(en, 1'b0);
    i_host.wr(8'h0c, 4'hf, 32'hffffffff);
    rchk(8'h0e, 32'h0);
    i_host.wr(8'h34, 4'hf, 32'h0);
    rchk(8'h34, 32'he0);
    rchk(8'h80, 32'h0);
    i_host.wr(8'h2c, 4'h3, 32'h1234cafe);
    i_host.wr(8'h2c, 4'hf, 32'h5678beef);
    i_host.wr(8'h2c, 4'hf, 32'h0);
    rchk(8'h2c, 32'h5678cafe);
    mchk(36'h0_0000_0abc, 1'b0, 12'h0);
    i_host.wr(8'h40, 4'hf, 32'hfed19fff);
    i_host.wr(8'h44, 4'hf, 32'h5);
    rchk(8'h40, 32'hfed19001);
    rchk(8'h44, 32'h5);
    mchk(36'h5_fed1_9abc, 1'b1, 12'habc);
    mchk(36'h5_fed1_aabc, 1'b0, 12'h0);
    mchk(36'h4_fed1_9abc, 1'b0, 12'h0);
    @(posedge core_clk_i) lock_mode_i <= 1'b1;
    i_host.wr(8'h40, 4'hf, 32'h0);
    rchk(8'h40, 32'hfed19001);
    mchk(36'h5_fed1_9123, 1'b1, 12'h123);
    @(posedge core_clk_i) lock_mode_i <= 1'b0;
    i_host.wr(8'h40, 4'h1, 32'h0);
    rchk(8'h40, 32'hfed19000);
    mchk(36'h5_fed1_9abc, 1'b0, 12'h0);
    @(posedge core_clk_i) rstn_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rchk(8'h2c, 32'h0);
    i_host.wr(8'h2c, 4'hf, 32'h9abc1357);
    rchk(8'h2c, 32'h9abc1357);
    rchk(8'h40, 32'h0);
    give_verdict;
  end
endmodule
